// ===== hw/drive_cfg.sv
// Module: drive configuration bits with AXI4-Lite slave and drive-loop steering
// How it works
// - Bit 5 picks rotating-mass loop, resets open
// - Supply correction applied unless disabled
// - Realtime samples signed at 0, unsigned at 1
// - Resonant amplitude updates once or twice per cycle
// - Input amplitude from PWM duty or analog level
// - Open-loop resonant drive ignores actual resonance
// - PWM frequency divided by 128 for commutation
// - Open-loop frequency from 7-bit period field
// - Resonant bit 7 at 0 selects auto-resonance tracking
// - Supply correction off is bit 4, resets 0
//
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module drive_cfg
  import drive_cfg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pwm_in,
  input wire logic [SAMPLE_W-1:0] analog_level,
  input wire logic [SAMPLE_W-1:0] realtime_sample,
  input wire logic [SAMPLE_W-1:0] supply_gain,
  input wire logic drive_cycle_start,
  input wire logic drive_cycle_half,
  input wire logic resonance_tick,
  output logic [SAMPLE_W-1:0] drive_amplitude_q,
  output logic [SAMPLE_W-1:0] input_amplitude_q,
  output logic erm_closed_loop_q,
  output logic lra_auto_resonance_q,
  output logic drive_commutation_q,
  output logic [PERIOD_W-1:0] drive_period_q,
  output logic config_invalid_q
);
  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [7:0] ctrl_q;
  logic [PERIOD_W-1:0] period_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_held_q;
  logic w_held_q;
  drive_cfg_s cfg;

  assign cfg.lra_open_loop = ctrl_q[BIT_LRA_LOOP];
  assign cfg.input_analog = ctrl_q[BIT_INPUT_TYPE];
  assign cfg.rotating_mass_loop_select = ctrl_q[BIT_ERM_LOOP];
  assign cfg.supply_correction_off = ctrl_q[BIT_SUPPLY_OFF];
  assign cfg.realtime_sample_signedness = ctrl_q[BIT_SIGNEDNESS];
  assign cfg.lra_twice_per_cycle = ctrl_q[BIT_LRA_UPDATE];

  wire logic do_write = aw_held_q && w_held_q && !s_axi_bvalid;
  wire logic wr_ctrl = do_write && awaddr_q == CTRL_OFFSET && wstrb_q[0];
  wire logic wr_period = do_write && awaddr_q == PERIOD_OFFSET && wstrb_q[0];

  // Address and data are latched independently, so either may arrive first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awaddr_q == CTRL_OFFSET || awaddr_q == PERIOD_OFFSET ||
                      awaddr_q == STATUS_OFFSET) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RESET;
      period_q <= PERIOD_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wdata_q[7:0];
      end
      if (wr_period) begin
        period_q <= wdata_q[PERIOD_W-1:0];
      end
    end
  end

  // Read path: one cycle from address to data; status reads live drive state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        case (s_axi_araddr)
          CTRL_OFFSET: s_axi_rdata <= {24'h000000, ctrl_q};
          PERIOD_OFFSET: s_axi_rdata <= {25'h0, period_q};
          STATUS_OFFSET: s_axi_rdata <= {23'h0, config_invalid_q, drive_amplitude_q};
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Drive steering
  // ****************************************************************
  logic [SAMPLE_W-1:0] pwm_high_q;
  logic [SAMPLE_W-1:0] pwm_total_q;
  logic pwm_last_q;
  logic div_commutation;
  logic [2*SAMPLE_W-1:0] duty_ratio;
  logic [PERIOD_W-1:0] ol_cnt_q;
  logic ol_commutation_q;
  logic [SAMPLE_W-1:0] sample_mag;
  logic [2*SAMPLE_W-1:0] scaled;
  wire logic lra_open_pwm = cfg.lra_open_loop && !cfg.input_analog;

  // Product kept at double width so a long high time cannot wrap before the divide
  assign duty_ratio = ((2*SAMPLE_W)'(pwm_high_q) * (2*SAMPLE_W)'({SAMPLE_W{1'b1}})) /
                      (2*SAMPLE_W)'(pwm_total_q);

  commutation_divider #(.DIV_W(PWM_DIV_W)) u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(lra_open_pwm),
    .pwm_in(pwm_in),
    .commutation_q(div_commutation),
    .half_tick_q()
  );

  // Duty estimate over one PWM period (saturating counters)
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_last_q <= 1'b0;
      pwm_high_q <= '0;
      pwm_total_q <= '0;
      input_amplitude_q <= '0;
    end else begin
      pwm_last_q <= pwm_in;
      // The rising-edge cycle is itself high, so both counts restart at one
      if (pwm_in && !pwm_last_q) begin
        pwm_high_q <= SAMPLE_W'(1'b1);
        pwm_total_q <= SAMPLE_W'(1'b1);
      end else begin
        if (pwm_in && !(&pwm_high_q)) pwm_high_q <= pwm_high_q + 1'b1;
        if (!(&pwm_total_q)) pwm_total_q <= pwm_total_q + 1'b1;
      end
      if (cfg.input_analog) begin
        input_amplitude_q <= analog_level;
      end else if (pwm_in && !pwm_last_q && pwm_total_q != '0) begin
        input_amplitude_q <= duty_ratio[SAMPLE_W-1:0];
      end
    end
  end

  // Free-running open-loop commutation from the fixed period field
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ol_cnt_q <= '0;
      ol_commutation_q <= 1'b0;
    end else if (resonance_tick) begin
      if (ol_cnt_q >= period_q) begin
        ol_cnt_q <= '0;
        ol_commutation_q <= ~ol_commutation_q;
      end else begin
        ol_cnt_q <= ol_cnt_q + 1'b1;
      end
    end
  end

  always_comb begin
    if (cfg.realtime_sample_signedness) begin
      sample_mag = realtime_sample;
    end else begin
      sample_mag = realtime_sample ^ HALF_SCALE;
    end
    scaled = sample_mag * supply_gain;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_amplitude_q <= '0;
    end else if (drive_cycle_start || (cfg.lra_twice_per_cycle && drive_cycle_half)) begin
      if (cfg.supply_correction_off) begin
        drive_amplitude_q <= sample_mag;
      end else begin
        drive_amplitude_q <= scaled[2*SAMPLE_W-1:SAMPLE_W];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      erm_closed_loop_q <= 1'b0;
      lra_auto_resonance_q <= 1'b1;
      drive_commutation_q <= 1'b0;
      drive_period_q <= PERIOD_RESET;
      config_invalid_q <= 1'b0;
    end else begin
      erm_closed_loop_q <= !cfg.rotating_mass_loop_select;
      lra_auto_resonance_q <= !cfg.lra_open_loop;
      drive_period_q <= period_q;
      // Unsupported pairing is flagged, not blocked
      config_invalid_q <= cfg.lra_open_loop && cfg.input_analog;
      drive_commutation_q <= lra_open_pwm ? div_commutation : ol_commutation_q;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_erm_loop_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 erm_closed_loop_q == !$past(ctrl_q[BIT_ERM_LOOP])) else $error("erm loop wrong");
  a_auto_res: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 lra_auto_resonance_q == !$past(ctrl_q[BIT_LRA_LOOP])) else $error("auto res wrong");
  a_ctrl_readback: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ctrl |=> ctrl_q == $past(wdata_q[7:0])) else $error("ctrl not stored");
  a_invalid_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    (cfg.lra_open_loop && cfg.input_analog) [*2] |-> config_invalid_q) else $error("flag");
  a_supply_off: assert property (@(posedge aclk) disable iff (!aresetn)
    (drive_cycle_start && cfg.supply_correction_off) |=> drive_amplitude_q == $past(sample_mag))
    else $error("supply off ignored");
  a_once_per_cycle: assert property (@(posedge aclk) disable iff (!aresetn)
    (!drive_cycle_start && !cfg.lra_twice_per_cycle) |=> $stable(drive_amplitude_q))
    else $error("extra update");
  a_period_out: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_period |=> ##1 drive_period_q == $past(wdata_q[PERIOD_W-1:0], 2)) else $error("period");
  a_analog_input: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg.input_analog |=> input_amplitude_q == $past(analog_level)) else $error("analog");
  a_signed_map: assert property (@(posedge aclk) disable iff (!aresetn)
    !cfg.realtime_sample_signedness |-> sample_mag[SAMPLE_W-1] != realtime_sample[SAMPLE_W-1])
    else $error("signed map");
endmodule
`default_nettype wire

// ===== hw/drive_cfg_pkg.sv
// Package: register map, field positions and reset values of the drive configuration block
package drive_cfg_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 4'h0;
  localparam logic [ADDR_W-1:0] PERIOD_OFFSET = 4'h4;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h8;
  localparam int BIT_LRA_UPDATE = 2;
  localparam int BIT_SIGNEDNESS = 3;
  localparam int BIT_SUPPLY_OFF = 4;
  localparam int BIT_ERM_LOOP = 5;
  localparam int BIT_INPUT_TYPE = 6;
  localparam int BIT_LRA_LOOP = 7;
  localparam int PERIOD_W = 7;
  localparam int SAMPLE_W = 8;
  localparam int PWM_DIV = 128;
  localparam int PWM_DIV_W = 7;
  localparam logic [7:0] CTRL_RESET = 8'h20;
  localparam logic [PERIOD_W-1:0] PERIOD_RESET = 7'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] HALF_SCALE = 8'h80;

  typedef struct packed {
    logic lra_open_loop;
    logic input_analog;
    logic rotating_mass_loop_select;
    logic supply_correction_off;
    logic realtime_sample_signedness;
    logic lra_twice_per_cycle;
  } drive_cfg_s;
endpackage

// ===== hw/commutation_divider.sv
// Module: divides PWM input edges by a fixed ratio to recover commutation
`timescale 1ns/1ps
`default_nettype none
module commutation_divider
  import drive_cfg_pkg::*;
#(
  parameter int DIV_W = PWM_DIV_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic pwm_in,
  output logic commutation_q,
  output logic half_tick_q
);
  logic pwm_last_q;
  logic [DIV_W-1:0] edge_cnt_q;
  wire logic pwm_rise = pwm_in & ~pwm_last_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_last_q <= 1'b0;
    end else begin
      pwm_last_q <= pwm_in;
    end
  end

  // A full count wrap is one commutation period; the midpoint and the wrap each give a half tick
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      edge_cnt_q <= '0;
      commutation_q <= 1'b0;
      half_tick_q <= 1'b0;
    end else begin
      half_tick_q <= 1'b0;
      if (pwm_rise) begin
        edge_cnt_q <= edge_cnt_q + 1'b1;
        if (edge_cnt_q == {1'b0, {(DIV_W-1){1'b1}}}) begin
          half_tick_q <= 1'b1;
        end
        if (&edge_cnt_q) begin
          commutation_q <= ~commutation_q;
          half_tick_q <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/pwm_source_model.sv
// PWM source and actuator-side edge counter facing the drive configuration block
`timescale 1ns/1ps
`default_nettype none
module pwm_source_model #(
  parameter int HALF = 4
) (
  input wire logic aclk,
  input wire logic run,
  input wire logic commutation,
  output logic pwm,
  output int rises,
  output int toggles
);
  int cnt;
  logic last_c;
  initial begin
    pwm = 0;
    rises = 0;
    toggles = 0;
    cnt = 0;
    last_c = 0;
  end
  // Square wave of period 2*HALF cycles, 128x the wanted commutation rate
  always @(posedge aclk) begin
    if (run) begin
      if (cnt == HALF - 1) begin
        cnt <= 0;
        pwm <= !pwm;
        if (!pwm) rises <= rises + 1;
      end else begin
        cnt <= cnt + 1;
      end
    end else begin
      cnt <= 0;
      pwm <= 0;
    end
  end
  always @(posedge aclk) begin
    last_c <= commutation;
    if (commutation !== last_c) toggles <= toggles + 1;
  end
endmodule
`default_nettype wire

// ===== bench/test_drive_cfg.sv
// Self-checking testbench of the drive configuration block
`timescale 1ns/1ps
`default_nettype none
module test_drive_cfg;
  import drive_cfg_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [3:0] awaddr = '0, araddr = '0, wstrb = 4'hf;
  logic [31:0] wdata = '0, rdata, d;
  logic awready, wready, bvalid, arready, rvalid, start = 0, half = 0, tick = 0, run = 0, pwm;
  logic erm_cl, lra_auto, comm, cfg_inv;
  logic [1:0] bresp, rresp, r;
  logic [7:0] alev = '0, sample = '0, gain = 8'h80, amp, in_amp;
  logic [6:0] per;
  int err_count = 0, total_checks = 0, cycles = 0, rises, toggles, n0, r0;
  drive_cfg dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pwm_in(pwm), .analog_level(alev),
    .realtime_sample(sample), .supply_gain(gain), .drive_cycle_start(start),
    .drive_cycle_half(half), .resonance_tick(tick), .drive_amplitude_q(amp),
    .input_amplitude_q(in_amp), .erm_closed_loop_q(erm_cl),
    .lra_auto_resonance_q(lra_auto), .drive_commutation_q(comm),
    .drive_period_q(per), .config_invalid_q(cfg_inv));
  pwm_source_model src (.aclk(aclk), .run(run), .commutation(comm), .pwm(pwm),
    .rises(rises), .toggles(toggles));
  // ****************
  // Shared tasks
  // ****************
  always #2.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      $display("ERROR %0t: run did not finish", $time);
      final_report();
    end
  end
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task axw(input logic [3:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
    end while (!bvalid);
    r = bresp;
    bready <= 0;
  endtask
  task axr(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask
  // ****************
  // Scenarios
  // ****************
  task t_reset;
    axr(CTRL_OFFSET);
    chk(d, 32'h20);
    chk(erm_cl, 1'b0);
    chk(lra_auto, 1'b1);
  endtask
  task t_regs;
    // Open loop with analog input is illegal for a host; the flag must catch it
    axw(CTRL_OFFSET, 32'hc0);
    chk(r, RESP_OKAY);
    axw(PERIOD_OFFSET, 32'h55);
    wstrb <= 4'h0;
    axw(CTRL_OFFSET, 32'h00);
    wstrb <= 4'hf;
    axr(CTRL_OFFSET);
    chk(d, 32'hc0);
    axr(PERIOD_OFFSET);
    chk(d, 32'h55);
    chk(erm_cl, 1'b1);
    chk(lra_auto, 1'b0);
    chk(per, 7'h55);
    chk(cfg_inv, 1'b1);
    @(posedge aclk);
    alev <= 8'h5a;
    repeat (3) @(posedge aclk);
    chk(in_amp, 8'h5a);
    axr(4'hc);
    chk(r, RESP_SLVERR);
    chk(d, 32'h0);
  endtask
  task t_amp;
    logic [7:0] tc[5], ts[5], te[5];
    logic th[5];
    tc = '{8'h38, 8'h30, 8'h08, 8'h18, 8'h1c};
    ts = '{8'h35, 8'h35, 8'h40, 8'h11, 8'h11};
    te = '{8'h35, 8'hb5, 8'h20, 8'h20, 8'h11};
    th = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 5; i++) begin
      axw(CTRL_OFFSET, {24'h0, tc[i]});
      @(posedge aclk);
      sample <= ts[i];
      start <= !th[i];
      half <= th[i];
      @(posedge aclk);
      start <= 0;
      half <= 0;
      repeat (3) @(posedge aclk);
      chk(amp, te[i]);
    end
    axr(STATUS_OFFSET);
    chk(r, RESP_OKAY);
    chk(d, 32'h11);
  endtask
  task t_ol;
    // Period counter path: a toggle every period+1 ticks
    axw(CTRL_OFFSET, 32'h00);
    axw(PERIOD_OFFSET, 32'h03);
    n0 = toggles;
    @(posedge aclk);
    tick <= 1;
    repeat (40) @(posedge aclk);
    tick <= 0;
    repeat (10) @(posedge aclk);
    chk(toggles - n0, 10);
    chk(per, 7'h03);
  endtask
  task t_pwm;
    // Period ticks run flat out meanwhile and must not disturb commutation
    axw(CTRL_OFFSET, 32'h80);
    n0 = toggles;
    r0 = rises;
    @(posedge aclk);
    run <= 1;
    tick <= 1;
    while (rises - r0 < 384) @(posedge aclk);
    run <= 0;
    tick <= 0;
    repeat (10) @(posedge aclk);
    chk(toggles - n0, 3);
    chk(in_amp, 8'h7f);
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    t_reset();
    t_regs();
    t_amp();
    t_ol();
    t_pwm();
    final_report();
  end
endmodule
`default_nettype wire
